// File: core/ics_ctrl.sv
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "ics_defs.svh"
// ----------------------------------------
// What this block does
// - two saved contexts, main and low handler; nesting at most two deep
// - on entry the pc goes to the hardware return stack, not shadows
// - on entry status, working_register, bsr, pointers, product, pc latches are saved, except when a software shadow write lands in the same cycle
// - after saving working_register, load working_register with the resolved vector number
// - save and restore ignore the multi-vector enable setting
// - with priority levels off only the main context is saved
// - both contexts reached through one shadow register set, bank 56
// - select 0 shows main context, select 1 shows low handler context
// - high handler exit restores the low handler context if one was interrupted, else the main context
// - low handler exit restores the main context
// - shadows are software read/write; written values are what is restored
// - flags set by hardware regardless of enables
// - flag 1 means event; only software writing zero or a reset clears it
// - flags eight: timer5 gate bit 7, timer5 overflow bit 6, others zero
// - flags nine: cell3 bit 3, wavegen3 bit 2, ccp3 bit 1, timer6 bit 0
// - all flags reset to zero on every reset
// - priority enable permits a second nested context level
// ----------------------------------------
module ics_ctrl
    import ics_pkg::*;
(
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            hsel,
    input  wire logic [11:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    input  wire ics_cpu_req_type cpu_req,
    output ics_cpu_rsp_type      cpu_rsp,
    input  wire logic [5:0]      event_in,
    output logic                 irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic          ph_valid;
        logic          ph_write;
        logic [11:0]   ph_addr;
        logic [31:0]   rdata;
        logic [2:0]    ctrl;
        ics_level_type level;
        logic [7:0]    flags8;
        logic [7:0]    flags9;
        logic [3:0]    irq_stat;
        logic [3:0]    irq_mask;
        logic          irq;
        ics_cpu_rsp_type rsp;
        logic          rd_pend;
    } ics_state_type;

    ics_state_type s_q;
    ics_state_type s_d;

    logic        mem_we;
    logic        mem_wslot;
    ics_ctx_type mem_wctx;
    ics_ctx_type mem_rctx;
    logic        mem_rslot;

    logic exit_go;
    logic exit_slot;
    // exit borrows the read port for one cycle to fetch the slot it restores
    assign exit_go   = cpu_req.exit && s_q.level != ICS_MAIN && !cpu_req.entry;
    assign exit_slot = s_q.level == ICS_HIGH && s_q.ctrl[`ICS_CTRL_PRIO_BIT] &&
                       s_q.irq_stat[3];
    // low handler slot while select bit set and no exit, or during exit from a high handler that interrupted a low handler
    assign mem_rslot = exit_go ? exit_slot : s_q.ctrl[`ICS_CTRL_SHAD_BIT];

    ics_ctx_mem u_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (mem_we),
        .wr_slot (mem_wslot),
        .wr_ctx  (mem_wctx),
        .rd_slot (mem_rslot),
        .rd_ctx  (mem_rctx)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] shadow_field(input ics_ctx_type c, input logic [3:0] i);
        case (i)
            4'h0:    shadow_field = {8'h00, c.status};
            4'h1:    shadow_field = {8'h00, c.working_register};
            4'h2:    shadow_field = {8'h00, c.bank_select_register};
            4'h3:    shadow_field = c.fsr0;
            4'h4:    shadow_field = c.fsr1;
            4'h5:    shadow_field = c.fsr2;
            4'h6:    shadow_field = {8'h00, c.prodl};
            4'h7:    shadow_field = {8'h00, c.prodh};
            4'h8:    shadow_field = {8'h00, c.pclath};
            4'h9:    shadow_field = {8'h00, c.pclatu};
            default: shadow_field = 16'h0000;
        endcase
    endfunction

    function automatic ics_ctx_type shadow_put(input ics_ctx_type c, input logic [3:0] i,
                                               input logic [15:0] v);
        ics_ctx_type r;
        r = c;
        case (i)
            4'h0:    r.status = v[7:0];
            4'h1:    r.working_register   = v[7:0];
            4'h2:    r.bank_select_register    = v[7:0];
            4'h3:    r.fsr0   = v;
            4'h4:    r.fsr1   = v;
            4'h5:    r.fsr2   = v;
            4'h6:    r.prodl  = v[7:0];
            4'h7:    r.prodh  = v[7:0];
            4'h8:    r.pclath = v[7:0];
            4'h9:    r.pclatu = v[7:0];
            default: r = c;
        endcase
        shadow_put = r;
    endfunction

    function automatic logic is_shadow(input logic [11:0] a);
        is_shadow = (a >= `ICS_OFF_SHADOW_BASE) &&
                    (a < `ICS_OFF_SHADOW_BASE + 12'(4 * `ICS_SHADOW_REGS));
    endfunction

    logic [3:0] sh_idx;
    assign sh_idx = 4'((s_q.ph_addr - `ICS_OFF_SHADOW_BASE) >> 2);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [7:0] ev8;
        logic [7:0] ev9;
        logic [3:0] ev_irq;
        logic [7:0] clr8;
        logic [7:0] clr9;
        logic [3:0] clr_irq;
        logic       ctx_wr;
        ev8     = '0;
        ev9     = '0;
        ev_irq  = '0;
        clr8    = '0;
        clr9    = '0;
        clr_irq = '0;
        ctx_wr  = 1'b0;
        s_d     = s_q;
        mem_we    = 1'b0;
        mem_wslot = 1'b0;
        mem_wctx  = cpu_req.ctx;

        s_d.rsp.push      = 1'b0;
        s_d.rsp.load_working_register = 1'b0;
        s_d.rsp.restore   = 1'b0;
        s_d.rd_pend       = 1'b0;

        // bus data phase
        if (s_q.ph_valid && s_q.ph_write) begin
            if (s_q.ph_addr == `ICS_OFF_CTRL) begin
                s_d.ctrl = hwdata[2:0];
            end else if (s_q.ph_addr == `ICS_OFF_FLAGS8) begin
                clr8 = ~hwdata[7:0] & `ICS_F8_IMPL_MASK;
            end else if (s_q.ph_addr == `ICS_OFF_FLAGS9) begin
                clr9 = ~hwdata[7:0] & `ICS_F9_IMPL_MASK;
            end else if (s_q.ph_addr == `ICS_OFF_IRQ_STAT) begin
                clr_irq = hwdata[3:0];
            end else if (s_q.ph_addr == `ICS_OFF_IRQ_MASK) begin
                s_d.irq_mask = hwdata[3:0];
            end else if (is_shadow(s_q.ph_addr)) begin
                // software edit lands in the slot being read: the select bit's slot, or the exit slot during exit
                ctx_wr    = 1'b1;
                mem_we    = 1'b1;
                mem_wslot = mem_rslot;
                mem_wctx  = shadow_put(mem_rctx, sh_idx, hwdata[15:0]);
            end
        end

        // hardware events, set beats clear
        ev8[`ICS_F8_GATE5_BIT] = event_in[0];
        ev8[`ICS_F8_OVF5_BIT]  = event_in[1];
        ev9[`ICS_F9_CLC3_BIT]  = event_in[2];
        ev9[`ICS_F9_CWG3_BIT]  = event_in[3];
        ev9[`ICS_F9_CCP3_BIT]  = event_in[4];
        ev9[`ICS_F9_TMR6_BIT]  = event_in[5];
        s_d.flags8 = ((s_q.flags8 & ~clr8) | ev8) & `ICS_F8_IMPL_MASK;
        s_d.flags9 = ((s_q.flags9 & ~clr9) | ev9) & `ICS_F9_IMPL_MASK;

        // context sequencing; multi-vector bit never consulted
        if (cpu_req.entry && s_q.level != ICS_HIGH) begin
            s_d.rsp.push      = 1'b1;
            s_d.rsp.push_pc   = cpu_req.pc;
            s_d.rsp.load_working_register = 1'b1;
            s_d.rsp.working_register_val  = {1'b0, cpu_req.vector};
            ev_irq[0]         = 1'b1;
            if (!ctx_wr) begin
                mem_we    = 1'b1;
                mem_wctx  = cpu_req.ctx;
                mem_wslot = (s_q.level == ICS_LOW);
            end
            if (!s_q.ctrl[`ICS_CTRL_PRIO_BIT]) begin
                s_d.level = ICS_HIGH;
            end else if (s_q.level == ICS_MAIN && !cpu_req.high_prio) begin
                s_d.level = ICS_LOW;
            end else begin
                s_d.level = ICS_HIGH;
            end
            if (s_q.level == ICS_LOW && !s_q.ctrl[`ICS_CTRL_PRIO_BIT]) begin
                s_d.level = ICS_HIGH;
            end
        end else if (cpu_req.entry) begin
            ev_irq[2] = 1'b1;
        end else if (exit_go) begin
            s_d.rd_pend = 1'b1;
            ev_irq[1]   = 1'b1;
            // high exit back to low only if a low handler was interrupted
            if (exit_slot) begin
                s_d.level = ICS_LOW;
            end else begin
                s_d.level = ICS_MAIN;
            end
        end

        // restore a cycle after exit, from the store, so software edits apply
        if (s_q.rd_pend) begin
            s_d.rsp.restore     = 1'b1;
            s_d.rsp.restore_ctx = mem_rctx;
        end

        // nested-low marker kept in a spare status bit
        ev_irq[3] = 1'b0;
        s_d.irq_stat = ((s_q.irq_stat & ~clr_irq) | ev_irq);
        if (cpu_req.entry && s_q.level == ICS_LOW) begin
            s_d.irq_stat[3] = 1'b1;
        end else if (cpu_req.exit && s_q.level == ICS_HIGH) begin
            s_d.irq_stat[3] = 1'b0;
        end else if (cpu_req.exit && s_q.level == ICS_LOW) begin
            s_d.irq_stat[3] = 1'b0;
        end
        s_d.irq = |(s_d.irq_stat[2:0] & s_d.irq_mask[2:0]);

        // read data for the next data phase
        s_d.rdata = '0;
        if (s_q.ph_valid && !s_q.ph_write && is_shadow(s_q.ph_addr)) begin
            s_d.rdata = {16'h0000, shadow_field(mem_rctx, sh_idx)};
        end

        // bus address phase
        s_d.ph_valid = hsel && hready && htrans[1];
        s_d.ph_write = hwrite;
        s_d.ph_addr  = haddr;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr == `ICS_OFF_CTRL) begin
                s_d.rdata = {29'h0, s_q.ctrl};
            end else if (haddr == `ICS_OFF_STATUS) begin
                s_d.rdata = {22'h0, `ICS_SHADOW_BANK, s_q.level};
            end else if (haddr == `ICS_OFF_FLAGS8) begin
                s_d.rdata = {24'h0, s_d.flags8};
            end else if (haddr == `ICS_OFF_FLAGS9) begin
                s_d.rdata = {24'h0, s_d.flags9};
            end else if (haddr == `ICS_OFF_IRQ_STAT) begin
                s_d.rdata = {29'h0, s_d.irq_stat[2:0]};
            end else if (haddr == `ICS_OFF_IRQ_MASK) begin
                s_d.rdata = {28'h0, s_q.irq_mask};
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // shadow reads need one wait state for the store read register
    logic wait_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_q    <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= '0;
        end else begin
            wait_q    <= hsel && hready && htrans[1] && !hwrite && is_shadow(haddr);
            hreadyout <= !(hsel && hready && htrans[1] && !hwrite && is_shadow(haddr));
            hrdata    <= (wait_q) ? {16'h0000, shadow_field(mem_rctx, 4'((s_q.ph_addr -
                         `ICS_OFF_SHADOW_BASE) >> 2))} : s_d.rdata;
        end
    end

    assign hresp   = 1'b0;
    assign cpu_rsp = s_q.rsp;
    assign irq     = s_q.irq;
endmodule

// File: shared/ics_defs.svh
`ifndef ICS_DEFS_SVH
`define ICS_DEFS_SVH

// ----------------------------------------
// register byte offsets on the bus
// ----------------------------------------
`define ICS_OFF_CTRL        12'h000
`define ICS_OFF_STATUS      12'h004
`define ICS_OFF_FLAGS8      12'h008
`define ICS_OFF_FLAGS9      12'h00C
`define ICS_OFF_IRQ_STAT    12'h010
`define ICS_OFF_IRQ_MASK    12'h014
`define ICS_OFF_SHADOW_BASE 12'h040
`define ICS_SHADOW_REGS     12

// ----------------------------------------
// field positions
// ----------------------------------------
`define ICS_CTRL_PRIO_BIT   0
`define ICS_CTRL_MVEC_BIT   1
`define ICS_CTRL_SHAD_BIT   2
`define ICS_F8_GATE5_BIT    7
`define ICS_F8_OVF5_BIT     6
`define ICS_F9_CLC3_BIT     3
`define ICS_F9_CWG3_BIT     2
`define ICS_F9_CCP3_BIT     1
`define ICS_F9_TMR6_BIT     0
`define ICS_F8_IMPL_MASK    8'hC0
`define ICS_F9_IMPL_MASK    8'h0F

// ----------------------------------------
// reset values and shadow bank number
// ----------------------------------------
`define ICS_FLAGS_RESET     8'h00
`define ICS_CTRL_RESET      3'h0
`define ICS_SHADOW_BANK     8'h38

`endif

// File: shared/ics_pkg.sv
package ics_pkg;

    typedef enum logic [1:0] {
        ICS_MAIN,
        ICS_LOW,
        ICS_HIGH
    } ics_level_type;

    // one saved cpu context: status, working_register, bsr, fsr0..2, product_result_registers, pc_latch_high_upper
    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  working_register;
        logic [7:0]  bank_select_register;
        logic [15:0] fsr0;
        logic [15:0] fsr1;
        logic [15:0] fsr2;
        logic [7:0]  prodl;
        logic [7:0]  prodh;
        logic [7:0]  pclath;
        logic [7:0]  pclatu;
    } ics_ctx_type;

    typedef struct packed {
        logic        entry;
        logic        high_prio;
        logic [6:0]  vector;
        logic [20:0] pc;
        logic        exit;
        ics_ctx_type ctx;
    } ics_cpu_req_type;

    typedef struct packed {
        logic        push;
        logic [20:0] push_pc;
        logic        load_working_register;
        logic [7:0]  working_register_val;
        logic        restore;
        ics_ctx_type restore_ctx;
    } ics_cpu_rsp_type;

endpackage

// File: core/ics_ctx_mem.sv
`timescale 1ns/1ps
// two-entry context store; slot 0 main, slot 1 low handler
module ics_ctx_mem
    import ics_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        wr_en,
    input  wire logic        wr_slot,
    input  wire ics_ctx_type wr_ctx,
    input  wire logic        rd_slot,
    output ics_ctx_type      rd_ctx
);
    ics_ctx_type mem_q [2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            rd_ctx   <= '0;
        end else begin
            if (wr_en) begin
                mem_q[wr_slot] <= wr_ctx;
            end
            // read register; write-through keeps same-slot view current
            rd_ctx <= (wr_en && wr_slot == rd_slot) ? wr_ctx : mem_q[rd_slot];
        end
    end
endmodule

// File: dv/ics_ctrl_checker.sv
`timescale 1ns/1ps
module ics_ctrl_checker
    import ics_pkg::*;
(
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            hreadyout,
    input wire logic            hresp,
    input wire ics_cpu_req_type cpu_req,
    input wire ics_cpu_rsp_type cpu_rsp
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb_main @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_PUSH_PC: assert property (
        cpu_rsp.push |-> $past(cpu_req.entry) && (cpu_rsp.push_pc == $past(cpu_req.pc)))
        else $error("push without entry or with wrong pc");
    AST_VEC_LOAD: assert property (
        cpu_rsp.load_working_register |-> cpu_rsp.working_register_val == {1'b0, $past(cpu_req.vector)})
        else $error("working register load is not the vector");
    AST_PUSH_PULSE: assert property (
        cpu_rsp.push |=> !cpu_rsp.push)
        else $error("push held longer than one cycle");
    AST_RESTORE_CAUSE: assert property (
        cpu_rsp.restore |-> $past(cpu_req.exit, 2))
        else $error("restore without exit");
    AST_RESTORE_PULSE: assert property (
        cpu_rsp.restore |=> !cpu_rsp.restore)
        else $error("restore held longer than one cycle");
    AST_NO_CLASH: assert property (
        !(cpu_rsp.push && cpu_rsp.restore))
        else $error("save and restore in one cycle");
    AST_WAIT_ONE: assert property (
        !hreadyout |=> hreadyout)
        else $error("shadow wait longer than one cycle");
    AST_OKAY: assert property (
        hresp == 1'b0)
        else $error("response not okay");
endmodule

bind ics_ctrl ics_ctrl_checker u_chk (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .cpu_req   (cpu_req),
    .cpu_rsp   (cpu_rsp)
);

// File: dv/ics_cpu_model.sv
`timescale 1ns/1ps
module ics_cpu_model
    import ics_pkg::*;
(
    input  wire logic            hclk,
    output ics_cpu_req_type      cpu_req,
    input  wire ics_cpu_rsp_type cpu_rsp
);
    logic [20:0] pc_seen;
    logic [7:0]  vec_seen;
    ics_ctx_type ctx_seen;

    initial cpu_req = '0;

    // ----------------------------------------
    // handler entry and exit
    // ----------------------------------------
    task automatic enter(input logic hp, input logic [6:0] v, input logic [20:0] pc,
                         input ics_ctx_type c);
        pc_seen = 'x;
        vec_seen = 'x;
        @(posedge hclk);
        cpu_req.entry <= 1'b1;
        cpu_req.high_prio <= hp;
        cpu_req.vector <= v;
        cpu_req.pc <= pc;
        cpu_req.ctx <= c;
        @(posedge hclk);
        cpu_req.entry <= 1'b0;
        // core moves on at once; a late capture would see garbage
        cpu_req.pc <= ~pc;
        cpu_req.ctx <= ~c;
        for (int i = 0; i < 8; i++) begin
            @(posedge hclk);
            if (cpu_rsp.push === 1'b1) pc_seen = cpu_rsp.push_pc;
            if (cpu_rsp.load_working_register === 1'b1) vec_seen = cpu_rsp.working_register_val;
        end
    endtask

    task automatic leave();
        ctx_seen = 'x;
        @(posedge hclk);
        cpu_req.exit <= 1'b1;
        @(posedge hclk);
        cpu_req.exit <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge hclk);
            if (cpu_rsp.restore === 1'b1) ctx_seen = cpu_rsp.restore_ctx;
        end
    endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
`include "ics_defs.svh"
module tb
    import ics_pkg::*;
;
    logic            hclk = 1'b0;
    logic            hresetn = 1'b0;
    logic            hsel = 1'b0;
    logic [11:0]     haddr = 12'h000;
    logic [1:0]      htrans = 2'b00;
    logic            hwrite = 1'b0;
    logic [2:0]      hsize = 3'b010;
    logic [31:0]     hwdata = 32'h0000_0000;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic            hresp;
    logic [5:0]      event_in = 6'h00;
    logic            irq;
    ics_cpu_req_type cpu_req;
    ics_cpu_rsp_type cpu_rsp;
    int              err_total = 0;
    int              samples_checked = 0;
    int              seed = 97;
    int              cycles = 0;
    logic [31:0]     rd;
    logic [7:0]      f8, f9, wv;
    logic [5:0]      ev;
    logic [6:0]      v;
    logic [20:0]     pc;
    logic [31:0]     ctrl;
    ics_ctx_type     ca, cb, cc;

    always #2 hclk = ~hclk;

    ics_ctrl u_ics_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .event_in(event_in), .irq(irq));
    ics_cpu_model u_ics_cpu_model (.hclk(hclk), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic summarize();
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            summarize();
        end
    end

    task automatic chk_w(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic chk_c(input string name, input ics_ctx_type exp, input ics_ctx_type got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [31:0] shadow_exp(input ics_ctx_type c, input int i);
        case (i)
            0: return {24'h00_0000, c.status};
            1: return {24'h00_0000, c.working_register};
            2: return {24'h00_0000, c.bank_select_register};
            3: return {16'h0000, c.fsr0};
            4: return {16'h0000, c.fsr1};
            5: return {16'h0000, c.fsr2};
            6: return {24'h00_0000, c.prodl};
            7: return {24'h00_0000, c.prodh};
            8: return {24'h00_0000, c.pclath};
            default: return {24'h00_0000, c.pclatu};
        endcase
    endfunction

    function automatic ics_ctx_type rand_ctx();
        logic [127:0] t;
        t = {$random(seed), $random(seed), $random(seed), $random(seed)};
        return t[103:0];
    endfunction

    task automatic shadow_all(input ics_ctx_type c, input logic sel);
        xfer(1'b1, `ICS_OFF_CTRL, {ctrl[31:3], sel, ctrl[1:0]});
        for (int i = 0; i < 10; i++) begin
            xfer(1'b0, `ICS_OFF_SHADOW_BASE + 12'(4 * i), 32'h0000_0000);
            chk_w("shadow", shadow_exp(c, i), rd);
        end
    endtask

    task automatic chk_lvl(input logic [1:0] l);
        xfer(1'b0, `ICS_OFF_STATUS, 32'h0000_0000);
        chk_w("status", {22'h00_0000, `ICS_SHADOW_BANK, l}, rd);
    endtask

    task automatic go_in(input logic hp, input ics_ctx_type c);
        v = $random(seed);
        pc = $random(seed);
        u_ics_cpu_model.enter(hp, v, pc, c);
        chk_w("push_pc", {11'h000, pc}, {11'h000, u_ics_cpu_model.pc_seen});
        chk_w("working_register_val", {25'h000_0000, v}, {24'h00_0000, u_ics_cpu_model.vec_seen});
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        do_reset();
        xfer(1'b0, `ICS_OFF_CTRL, 32'h0000_0000);
        chk_w("ctrl", 32'h0000_0000, rd);
        chk_lvl(2'b00);
        f8 = 8'h00;
        f9 = 8'h00;
        for (int n = 0; n < 14; n++) begin
            ev = (n == 0) ? 6'h3F : 6'($random(seed));
            @(posedge hclk);
            event_in <= ev;
            @(posedge hclk);
            event_in <= 6'h00;
            f8 = f8 | {ev[0], ev[1], 6'h00};
            f9 = f9 | {4'h0, ev[2], ev[3], ev[4], ev[5]};
            xfer(1'b0, `ICS_OFF_FLAGS8, 32'h0000_0000);
            chk_w("flags8", {24'h00_0000, f8}, rd);
            xfer(1'b0, `ICS_OFF_FLAGS9, 32'h0000_0000);
            chk_w("flags9", {24'h00_0000, f9}, rd);
            wv = $random(seed);
            xfer(1'b1, `ICS_OFF_FLAGS8, {24'h00_0000, wv});
            xfer(1'b1, `ICS_OFF_FLAGS9, {24'h00_0000, ~wv});
            f8 = f8 & wv;
            f9 = f9 & ~wv;
            xfer(1'b0, `ICS_OFF_FLAGS9, 32'h0000_0000);
            chk_w("flags9", {24'h00_0000, f9}, rd);
        end
        xfer(1'b0, `ICS_OFF_FLAGS8, 32'h0000_0000);
        chk_w("flags8", {24'h00_0000, f8}, rd);
        event_in <= 6'h3F;
        do_reset();
        event_in <= 6'h00;
        xfer(1'b0, `ICS_OFF_FLAGS8, 32'h0000_0000);
        chk_w("flags8", 32'h0000_0000, rd);
        xfer(1'b0, `ICS_OFF_FLAGS9, 32'h0000_0000);
        chk_w("flags9", 32'h0000_0000, rd);
        for (int m = 0; m < 2; m++) begin
            ctrl = {30'h0000_0000, m[0], 1'b1};
            xfer(1'b1, `ICS_OFF_CTRL, ctrl);
            ca = rand_ctx();
            cb = rand_ctx();
            go_in(1'b0, ca);
            chk_lvl(2'b01);
            go_in(1'b1, cb);
            chk_lvl(2'b10);
            shadow_all(ca, 1'b0);
            shadow_all(cb, 1'b1);
            cb.working_register = $random(seed);
            xfer(1'b1, `ICS_OFF_SHADOW_BASE + 12'h004, {24'h00_0000, cb.working_register});
            u_ics_cpu_model.leave();
            chk_c("restore", cb, u_ics_cpu_model.ctx_seen);
            chk_lvl(2'b01);
            u_ics_cpu_model.leave();
            chk_c("restore", ca, u_ics_cpu_model.ctx_seen);
            chk_lvl(2'b00);
        end
        ctrl = 32'h0000_0000;
        xfer(1'b1, `ICS_OFF_CTRL, ctrl);
        cc = rand_ctx();
        go_in(1'b1, cc);
        shadow_all(cb, 1'b1);
        shadow_all(cc, 1'b0);
        u_ics_cpu_model.leave();
        chk_c("restore", cc, u_ics_cpu_model.ctx_seen);
        // stale status cleared before the mask opens
        xfer(1'b1, `ICS_OFF_IRQ_STAT, 32'h0000_0007);
        xfer(1'b1, `ICS_OFF_IRQ_MASK, 32'h0000_0007);
        go_in(1'b0, ca);
        chk_w("irq", 32'h0000_0001, {31'h0000_0000, irq});
        xfer(1'b0, `ICS_OFF_IRQ_STAT, 32'h0000_0000);
        chk_w("irq_stat", 32'h0000_0001, rd);
        xfer(1'b1, `ICS_OFF_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk_w("irq", 32'h0000_0000, {31'h0000_0000, irq});
        xfer(1'b1, `ICS_OFF_IRQ_MASK, 32'h0000_0000);
        u_ics_cpu_model.leave();
        xfer(1'b0, `ICS_OFF_IRQ_STAT, 32'h0000_0000);
        chk_w("irq_stat", 32'h0000_0002, rd);
        chk_w("irq", 32'h0000_0000, {31'h0000_0000, irq});
        xfer(1'b1, 12'h100, 32'hFFFF_FFFF);
        xfer(1'b0, 12'h100, 32'h0000_0000);
        chk_w("unmapped", 32'h0000_0000, rd);
        summarize();
    end
endmodule
